//--- hdl/mid_pkg.sv
// constants, register map and field layout of the interrupt dispatch block
package mid_pkg;
    localparam logic [7:0] ADDR_EDGE_REG = 8'hbf;
    localparam logic [7:0] ADDR_STACK_REG = 8'hdf;
    localparam logic [7:0] ADDR_REQ_REG = 8'hc8;
    localparam logic [7:0] ADDR_IEN_REG = 8'hc9;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'he0;
    localparam logic [7:0] ADDR_EVT_MASK = 8'he1;

    localparam int GIE_BIT = 7;
    localparam logic GIE_RESET = 1'b0;
    localparam int STACK_W = 3;
    localparam logic [2:0] STACK_RESET = 3'h7;

    localparam int EDGE_SEL_LSB = 3;
    localparam logic [1:0] EDGE_SEL_RESET = 2'h0;
    localparam logic [1:0] EDGE_RSVD = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam int REQ_EXT0 = 0;
    localparam int REQ_EXT1 = 1;
    localparam int REQ_BTMR = 4;
    localparam int REQ_STMR = 5;
    localparam int REQ_RTMR = 6;
    localparam logic [7:0] REQ_IMPL_MASK = 8'h73;
    localparam logic [7:0] REQ_RESET = 8'h00;
    localparam logic [7:0] IEN_RESET = 8'h00;

    localparam int VECTOR_ADDR = 8;
    // timeout and power-down status bits sit in the top two flag bits
    localparam logic [7:0] PROCESSOR_FLAG_REG_SAVE_MASK = 8'h3f;

    localparam int EVT_TAKEN = 0;
    localparam int EVT_RETURN = 1;
    localparam int EVT_WAKE = 2;
    localparam int EVT_OVERWRITE = 3;
    localparam logic [7:0] EVT_IMPL_MASK = 8'h0f;
    localparam logic [7:0] EVT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    localparam logic PIN_IDLE = 1'b1;
endpackage

//--- hdl/mid_edge_if.sv
// edge events of one synchronised external interrupt pin
`timescale 1ns/1ns
`default_nettype none
interface mid_edge_if;
    logic rise;
    logic fall;
    logic level;
    modport src (output rise, output fall, output level);
    modport snk (input rise, input fall, input level);
endinterface
`default_nettype wire

//--- hdl/mid_pin_edge.sv
// three-stage pin synchroniser with agreed-level edge detection
`timescale 1ns/1ns
`default_nettype none
module mid_pin_edge (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    mid_edge_if.src o_edge
);
    logic [2:0] sync_q;
    logic level_q;
    logic rise_q;
    logic fall_q;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            sync_q <= {3{mid_pkg::PIN_IDLE}};
        else
            sync_q <= {sync_q[1:0], i_pin};
    end

    // only the second and third stages are compared; the first may be metastable
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            level_q <= mid_pkg::PIN_IDLE;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            rise_q <= (sync_q[2] == sync_q[1]) && sync_q[2] && !level_q;
            fall_q <= (sync_q[2] == sync_q[1]) && !sync_q[2] && level_q;
            if (sync_q[2] == sync_q[1])
                level_q <= sync_q[2];
        end
    end

    assign o_edge.rise = rise_q;
    assign o_edge.fall = fall_q;
    assign o_edge.level = level_q;

    a_edge_exclusive: assert property (@(posedge i_clk) disable iff (i_rst)
        !(rise_q && fall_q) and (rise_q |=> !rise_q))
        else $error("edge pulses overlap or repeat");
endmodule // mid_pin_edge
`default_nettype wire

//--- hdl/mid_dispatch.sv
// interrupt dispatch: request flags, global enable, return stack, save buffer
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module mid_dispatch #(
    parameter int PC_W = 13,
    parameter int STACK_DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_ext_irq_zero,
    input wire logic i_ext_irq_one,
    input wire logic i_basic_timer_ovf,
    input wire logic i_second_timer_ovf,
    input wire logic i_reload_timer_ovf,
    input wire logic i_powerdown,
    input wire logic i_irq_take,
    input wire logic [PC_W-1:0] i_ret_pc,
    input wire logic i_irq_return,
    input wire logic i_save,
    input wire logic i_restore,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_processor_flag_reg,
    output logic o_irq_req,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_global_irq_enable,
    output logic [7:0] o_acc_restore,
    output logic [7:0] o_processor_flag_reg_restore,
    output logic o_restore_load,
    output logic o_wakeup,
    output logic o_int
);
    mid_edge_if ext0_if ();
    mid_edge_if ext1_if ();

    mid_pin_edge u_ext0 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_ext_irq_zero),
        .o_edge(ext0_if.src)
    );

    mid_pin_edge u_ext1 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_ext_irq_one),
        .o_edge(ext1_if.src)
    );

    logic global_irq_enable_q;
    logic [2:0] sp_q;
    logic [1:0] ext0_edge_sel_q;
    logic [7:0] request_flag_q;
    logic [7:0] irq_enable_q;
    logic [7:0] evt_q;
    logic [7:0] evt_mask_q;
    logic [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
    logic [PC_W-1:0] pc_q;
    logic pc_load_q;
    logic irq_req_q;
    logic wake_q;
    logic wakeup_q;
    logic [7:0] acc_buf_q;
    logic [7:0] processor_flag_reg_buf_q;
    logic saved_q;
    logic restore_load_q;
    logic [7:0] rdata_q;
    logic int_q;

    logic ext0_hit;
    logic take_ok;
    logic ret_ok;
    logic pending;
    logic [2:0] sp_inc;
    logic [7:0] req_set;
    logic [7:0] evt_set;

    function automatic logic wr_at(input logic [7:0] addr);
        return i_wr && (i_addr == addr);
    endfunction

    function automatic logic edge_match(input logic [1:0] sel, input logic r, input logic f);
        case (sel)
            mid_pkg::EDGE_RISE: return r;
            mid_pkg::EDGE_FALL: return f;
            mid_pkg::EDGE_BOTH: return r | f;
            default: return 1'b0;
        endcase
    endfunction

    assign ext0_hit = edge_match(ext0_edge_sel_q, ext0_if.rise, ext0_if.fall);
    // a take is only honoured while the request is being offered
    assign take_ok = i_irq_take && irq_req_q && global_irq_enable_q;
    assign ret_ok = i_irq_return && !take_ok;
    assign sp_inc = sp_q + 3'h1;
    assign pending = global_irq_enable_q
        && ((|(request_flag_q & irq_enable_q & mid_pkg::REQ_IMPL_MASK)) || wake_q);

    always_comb
    begin
        req_set = 8'h00;
        req_set[mid_pkg::REQ_EXT0] = ext0_hit;
        req_set[mid_pkg::REQ_EXT1] = ext1_if.fall;
        req_set[mid_pkg::REQ_BTMR] = i_basic_timer_ovf;
        req_set[mid_pkg::REQ_STMR] = i_second_timer_ovf;
        req_set[mid_pkg::REQ_RTMR] = i_reload_timer_ovf;
    end

    // software may clear flags; a same-cycle hardware set still wins
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            request_flag_q <= mid_pkg::REQ_RESET;
        else if (wr_at(mid_pkg::ADDR_REQ_REG))
            request_flag_q <= (i_wdata & mid_pkg::REQ_IMPL_MASK) | req_set;
        else
            request_flag_q <= request_flag_q | req_set;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            irq_enable_q <= mid_pkg::IEN_RESET;
        else if (wr_at(mid_pkg::ADDR_IEN_REG))
            irq_enable_q <= i_wdata & mid_pkg::REQ_IMPL_MASK;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ext0_edge_sel_q <= mid_pkg::EDGE_SEL_RESET;
        else if (wr_at(mid_pkg::ADDR_EDGE_REG))
            ext0_edge_sel_q <= i_wdata[mid_pkg::EDGE_SEL_LSB +: 2];
    end

    // dispatch offer to the core; dropped at once on a take so it cannot be taken twice
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            irq_req_q <= 1'b0;
        else
            irq_req_q <= take_ok ? 1'b0 : pending;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            global_irq_enable_q <= mid_pkg::GIE_RESET;
        else if (take_ok)
            global_irq_enable_q <= 1'b0;
        else if (ret_ok)
            global_irq_enable_q <= 1'b1;
        else if (wr_at(mid_pkg::ADDR_STACK_REG))
            global_irq_enable_q <= i_wdata[mid_pkg::GIE_BIT];
    end

    // stack pointer counts down on a push; wraps silently past its depth
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            sp_q <= mid_pkg::STACK_RESET;
        else if (take_ok)
            sp_q <= sp_q - 3'h1;
        else if (ret_ok)
            sp_q <= sp_inc;
        else if (wr_at(mid_pkg::ADDR_STACK_REG))
            sp_q <= i_wdata[mid_pkg::STACK_W-1:0];
    end

    always_ff @(posedge i_clk)
    begin
        if (take_ok)
            stack_mem[sp_q] <= i_ret_pc;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pc_q <= '0;
            pc_load_q <= 1'b0;
        end
        else
        begin
            pc_load_q <= take_ok || ret_ok;
            if (take_ok)
                pc_q <= PC_W'(mid_pkg::VECTOR_ADDR);
            else if (ret_ok)
                pc_q <= stack_mem[sp_inc];
        end
    end

    // wake latch keeps the ext0 edge seen in power-down until the vector is taken
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wake_q <= 1'b0;
            wakeup_q <= 1'b0;
        end
        else
        begin
            wakeup_q <= i_powerdown && ext0_hit;
            if (i_powerdown && ext0_hit)
                wake_q <= 1'b1;
            else if (take_ok)
                wake_q <= 1'b0;
        end
    end

    // one buffer only: nested saves lose the outer context
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            acc_buf_q <= 8'h00;
            processor_flag_reg_buf_q <= 8'h00;
            saved_q <= 1'b0;
            restore_load_q <= 1'b0;
        end
        else
        begin
            restore_load_q <= i_restore;
            if (i_save)
            begin
                acc_buf_q <= i_acc;
                processor_flag_reg_buf_q <= i_processor_flag_reg & mid_pkg::PROCESSOR_FLAG_REG_SAVE_MASK;
                saved_q <= 1'b1;
            end
            else if (i_restore)
                saved_q <= 1'b0;
        end
    end

    always_comb
    begin
        evt_set = 8'h00;
        evt_set[mid_pkg::EVT_TAKEN] = take_ok;
        evt_set[mid_pkg::EVT_RETURN] = ret_ok;
        evt_set[mid_pkg::EVT_WAKE] = i_powerdown && ext0_hit;
        evt_set[mid_pkg::EVT_OVERWRITE] = i_save && saved_q;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            evt_q <= mid_pkg::EVT_RESET;
            evt_mask_q <= mid_pkg::MASK_RESET;
            int_q <= 1'b0;
        end
        else
        begin
            if (wr_at(mid_pkg::ADDR_EVT_STATUS))
                evt_q <= (evt_q & ~i_wdata) | evt_set;
            else
                evt_q <= evt_q | evt_set;
            if (wr_at(mid_pkg::ADDR_EVT_MASK))
                evt_mask_q <= i_wdata & mid_pkg::EVT_IMPL_MASK;
            int_q <= |(evt_q & evt_mask_q);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rdata_q <= 8'h00;
        else if (!i_rd)
            rdata_q <= 8'h00;
        else
        begin
            case (i_addr)
                mid_pkg::ADDR_EDGE_REG:
                    rdata_q <= {3'h0, ext0_edge_sel_q, 3'h0};
                mid_pkg::ADDR_STACK_REG:
                    rdata_q <= {global_irq_enable_q, 4'h0, sp_q};
                mid_pkg::ADDR_REQ_REG:
                    rdata_q <= request_flag_q;
                mid_pkg::ADDR_IEN_REG:
                    rdata_q <= irq_enable_q;
                mid_pkg::ADDR_EVT_STATUS:
                    rdata_q <= evt_q;
                mid_pkg::ADDR_EVT_MASK:
                    rdata_q <= evt_mask_q;
                default:
                    rdata_q <= 8'h00;
            endcase
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq_req = irq_req_q;
    assign o_pc_load = pc_load_q;
    assign o_pc_value = pc_q;
    assign o_global_irq_enable = global_irq_enable_q;
    assign o_acc_restore = acc_buf_q;
    assign o_processor_flag_reg_restore = processor_flag_reg_buf_q;
    assign o_restore_load = restore_load_q;
    assign o_wakeup = wakeup_q;
    assign o_int = int_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_take;
        take_ok;
    endsequence
    sequence s_vectored;
        pc_load_q && (pc_q == PC_W'(mid_pkg::VECTOR_ADDR)) && !global_irq_enable_q;
    endsequence
    sequence s_armed;
        global_irq_enable_q && !take_ok
            && (|(request_flag_q & irq_enable_q & mid_pkg::REQ_IMPL_MASK));
    endsequence

    a_no_dispatch_off: assert property (!global_irq_enable_q |=> !irq_req_q)
        else $error("dispatch offered with global enable clear");
    a_vector_entry: assert property (s_take |=> s_vectored)
        else $error("taken interrupt did not load vector");
    a_stack_push: assert property (take_ok |=> sp_q == $past(sp_q) - 3'h1)
        else $error("stack did not advance on take");
    a_save_copy: assert property (i_save |=> (acc_buf_q == $past(i_acc))
        && (processor_flag_reg_buf_q == ($past(i_processor_flag_reg) & mid_pkg::PROCESSOR_FLAG_REG_SAVE_MASK)))
        else $error("save buffer wrong");
    a_save_single: assert property (i_save ##1 (!i_save && !i_restore) [*2]
        |-> acc_buf_q == $past(i_acc, 2))
        else $error("save buffer changed without save");
    a_ext0_flag: assert property (ext0_hit |=> request_flag_q[mid_pkg::REQ_EXT0])
        else $error("ext0 edge lost");
    a_enabled_offer: assert property (s_armed |=> irq_req_q)
        else $error("enabled request not offered");
    a_wake_hold: assert property (i_powerdown && ext0_hit |=> wake_q && wakeup_q)
        else $error("wake edge not latched");
    a_edge_rsvd: assert property (ext0_edge_sel_q == mid_pkg::EDGE_RSVD |-> !ext0_hit)
        else $error("reserved edge select triggered");
    a_ext1_falling: assert property (ext1_if.fall |=> request_flag_q[mid_pkg::REQ_EXT1])
        else $error("ext1 falling edge lost");
    a_timer_flags: assert property (i_basic_timer_ovf || i_second_timer_ovf
        || i_reload_timer_ovf |=> |(request_flag_q & 8'h70))
        else $error("timer overflow flag lost");
    a_return_pop: assert property (ret_ok |=> pc_load_q
        && global_irq_enable_q && (sp_q == $past(sp_q) + 3'h1))
        else $error("return did not pop and re-enable");
endmodule // mid_dispatch
`default_nettype wire

//--- bench/mid_core_model.sv
// core sequencer model: takes the vector when asked and issues returns
`timescale 1ns/1ns
`default_nettype none
module mid_core_model #(
    parameter int PC_W = 13,
    parameter logic [12:0] RET_PC = 13'h01a5
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_irq_req,
    input wire logic i_pc_load,
    input wire logic [PC_W-1:0] i_pc_value,
    input wire logic i_slow,
    output logic o_irq_take,
    output logic [PC_W-1:0] o_ret_pc,
    output logic o_irq_return
);
    int load_cnt = 0;
    logic [PC_W-1:0] last_pc = '0;

    assign o_ret_pc = RET_PC[PC_W-1:0];

    // software side never reloads timer counts and only clears flags by writes
    initial
    begin
        o_irq_take = 1'b0;
        o_irq_return = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_irq_req === 1'b1 && i_rst === 1'b0)
            begin
                // a slow core leaves the request standing for a while
                if (i_slow === 1'b1)
                    repeat (5) @(posedge i_clk);
                o_irq_take <= 1'b1;
                @(posedge i_clk);
                o_irq_take <= 1'b0;
                @(posedge i_clk);
            end
        end
    end

    always @(posedge i_clk)
    begin
        if (i_pc_load === 1'b1)
        begin
            load_cnt <= load_cnt + 1;
            last_pc <= i_pc_value;
        end
    end

    task automatic do_return();
        @(posedge i_clk);
        o_irq_return <= 1'b1;
        @(posedge i_clk);
        o_irq_return <= 1'b0;
    endtask
endmodule // mid_core_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench of the interrupt dispatch block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic i_clk, i_rst, i_wr, i_rd, pin0, pin1, pd, save, restore, slow, wake_seen;
    logic [7:0] addr, wdata, rdata, acc, processor_flag_reg, acc_r, processor_flag_reg_r;
    logic [2:0] ovf;
    logic irq_req, take, ret, pc_load, global_irq_enable, rload, wakeup, irq_out;
    logic [12:0] ret_pc, pc;
    int mismatches = 0;
    int total_checks = 0;

    mid_dispatch dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_ext_irq_zero(pin0),
        .i_ext_irq_one(pin1), .i_basic_timer_ovf(ovf[0]), .i_second_timer_ovf(ovf[1]),
        .i_reload_timer_ovf(ovf[2]), .i_powerdown(pd), .i_irq_take(take),
        .i_ret_pc(ret_pc), .i_irq_return(ret), .i_save(save), .i_restore(restore),
        .i_acc(acc), .i_processor_flag_reg(processor_flag_reg), .o_irq_req(irq_req), .o_pc_load(pc_load),
        .o_pc_value(pc), .o_global_irq_enable(global_irq_enable), .o_acc_restore(acc_r),
        .o_processor_flag_reg_restore(processor_flag_reg_r), .o_restore_load(rload), .o_wakeup(wakeup),
        .o_int(irq_out));

    mid_core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_irq_req(irq_req),
        .i_pc_load(pc_load), .i_pc_value(pc), .i_slow(slow), .o_irq_take(take),
        .o_ret_pc(ret_pc), .o_irq_return(ret));

    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // the wake pulse stands one cycle only, so it is caught here
    always @(posedge i_clk)
        if (wakeup === 1'b1)
            wake_seen <= 1'b1;

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("read data", {8'h00, exp}, {8'h00, rdata});
    endtask

    // waits for the n-th vector or return load, then compares the address
    task automatic wait_pc(input int n, input logic [12:0] exp);
        int k;
        for (k = 0; k < 40 && core.load_cnt < n; k++)
            @(posedge i_clk);
        chk("load count", 16'(n), 16'(core.load_cnt));
        chk("pc value", {3'h0, exp}, {3'h0, core.last_pc});
    endtask

    task automatic buf_save(input logic [7:0] a, input logic [7:0] p);
        @(posedge i_clk);
        save <= 1'b1;
        acc <= a;
        processor_flag_reg <= p;
        @(posedge i_clk);
        save <= 1'b0;
    endtask

    initial
    begin
        int i;
        int s;
        i_rst = 1'b1;
        {i_wr, i_rd, pd, save, restore, slow, wake_seen, ovf} = '0;
        {pin0, pin1} = 2'b11;
        {addr, wdata, acc, processor_flag_reg} = '0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        tick(6);
        rd(8'hbf, 8'h00);
        rd(8'hdf, 8'h07);
        rd(8'hc8, 8'h00);
        rd(8'hc9, 8'h00);
        rd(8'he1, 8'h00);
        rd(8'h00, 8'h00);
        // timer overflows with every source enable off and global enable on still set their flags
        wr(8'hdf, 8'h87);
        for (i = 0; i < 3; i++)
        begin
            @(posedge i_clk);
            ovf[i] <= 1'b1;
            @(posedge i_clk);
            ovf[i] <= 1'b0;
            tick(2);
            chk("irq req", 16'h0, {15'h0, irq_req});
        end
        rd(8'hc8, 8'h70);
        wr(8'hdf, 8'h07);
        wr(8'hc9, 8'h70);
        tick(4);
        chk("irq req", 16'h0, {15'h0, irq_req});
        wr(8'hdf, 8'h87);
        wait_pc(1, 13'h0008);
        chk("global enable", 16'h0, {15'h0, global_irq_enable});
        rd(8'hdf, 8'h06);
        // basic timer flag is left standing for over half an rtc period before the clear
        tick(330);
        wr(8'hc8, 8'h00);
        core.do_return();
        wait_pc(2, 13'h01a5);
        chk("global enable", 16'h1, {15'h0, global_irq_enable});
        rd(8'hdf, 8'h87);
        rd(8'he0, 8'h03);
        chk("int out", 16'h0, {15'h0, irq_out});
        wr(8'he0, 8'hff);
        // every edge selection, both pin directions, ext0 enable off
        wr(8'hc9, 8'h00);
        for (s = 0; s < 4; s++)
        begin
            wr(8'hbf, 8'(s << 3));
            wr(8'hc8, 8'h00);
            @(posedge i_clk);
            pin0 <= 1'b0;
            tick(8);
            rd(8'hc8, {7'h0, s[1]});
            wr(8'hc8, 8'h00);
            @(posedge i_clk);
            pin0 <= 1'b1;
            tick(8);
            rd(8'hc8, {7'h0, s[0]});
        end
        // ext1 with a slow core: falling edge dispatches, rising edge does nothing
        slow <= 1'b1;
        wr(8'hc8, 8'h00);
        wr(8'hc9, 8'h02);
        @(posedge i_clk);
        pin1 <= 1'b0;
        wait_pc(3, 13'h0008);
        rd(8'hc8, 8'h02);
        wr(8'hc8, 8'h00);
        @(posedge i_clk);
        pin1 <= 1'b1;
        tick(8);
        rd(8'hc8, 8'h00);
        core.do_return();
        wait_pc(4, 13'h01a5);
        // wake from power-down on a matching ext0 edge, ext0 enable off
        slow <= 1'b0;
        wr(8'hc9, 8'h00);
        wr(8'hbf, 8'h10);
        pd <= 1'b1;
        @(posedge i_clk);
        pin0 <= 1'b0;
        wait_pc(5, 13'h0008);
        chk("wake pulse", 16'h1, {15'h0, wake_seen});
        pd <= 1'b0;
        pin0 <= 1'b1;
        wr(8'hc8, 8'h00);
        core.do_return();
        wait_pc(6, 13'h01a5);
        wr(8'he0, 8'hff);
        // two saves before one restore keep only the later one
        buf_save(8'ha5, 8'hff);
        buf_save(8'h3c, 8'hc1);
        tick(2);
        @(posedge i_clk);
        restore <= 1'b1;
        @(posedge i_clk);
        restore <= 1'b0;
        #1;
        chk("restore load", 16'h1, {15'h0, rload});
        chk("acc restore", 16'h003c, {8'h00, acc_r});
        chk("flag restore", 16'h0001, {8'h00, processor_flag_reg_r});
        rd(8'he0, 8'h08);
        wr(8'he1, 8'h08);
        tick(2);
        chk("int out", 16'h1, {15'h0, irq_out});
        wr(8'he0, 8'h08);
        tick(2);
        chk("int out", 16'h0, {15'h0, irq_out});
        test_done();
    end

    // the whole run needs well under two thousand cycles
    initial
    begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        test_done();
    end
endmodule // testbench
`default_nettype wire
